// ==== shared/pscp_pkg.sv ====
// Shared constants and types for the passive serial configuration port.
// Assumes both ends run on one 125 MHz clk with active-low async reset.
package pscp_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // Power-on reset delay, in microseconds, and its length in clk cycles
  localparam int POR_DELAY_US = 100;
  localparam int POR_CYCLES = (POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IMAGE_BITS_DEF = 64;
  localparam int BIT_CNT_W = 32;
  localparam int EXTRA_FALL_EDGES = 2;
  localparam int INIT_OPT_BIT = 0;
  localparam int CLK_DIV_HALF = 4;
  localparam int SYNC_RESET_VAL = 0;
  typedef enum logic [2:0] {
    PSCP_DEV_POR = 3'h0,
    PSCP_DEV_CLEAR = 3'h1,
    PSCP_DEV_LOAD = 3'h2,
    PSCP_DEV_INIT = 3'h3,
    PSCP_DEV_USER = 3'h4
  } pscp_dev_state_t;
  typedef enum logic [2:0] {
    PSCP_HOST_IDLE = 3'h0,
    PSCP_HOST_REQ = 3'h1,
    PSCP_HOST_WAIT = 3'h2,
    PSCP_HOST_SHIFT = 3'h3,
    PSCP_HOST_TAIL = 3'h4,
    PSCP_HOST_DONE = 3'h5
  } pscp_host_state_t;
endpackage

// ==== shared/pscp_if.sv ====
// Link wires between configuration host and device.
// Open-drain status and done lines are resolved here with pull-ups.
`timescale 1ns/1ns
interface pscp_if;
  logic config_request_n;
  logic config_clock;
  logic serial_config_data;
  logic status_out;
  logic status_oe_n;
  logic done_out;
  logic done_oe_n;
  logic config_status_n;
  logic config_complete;
  // Open drain: driven only low, pulled high otherwise
  assign config_status_n = status_oe_n ? 1'b1 : status_out;
  assign config_complete = done_oe_n ? 1'b1 : done_out;
  modport host (
    output config_request_n,
    output config_clock,
    output serial_config_data,
    input config_status_n,
    input config_complete
  );
  modport device (
    input config_request_n,
    input config_clock,
    input serial_config_data,
    output status_out,
    output status_oe_n,
    output done_out,
    output done_oe_n,
    input config_status_n,
    input config_complete
  );
endinterface

// ==== logic/pscp_device.sv ====
// Device end: power-on hold, serial load, done and init-complete signalling.
// Assumes the host drives config_clock and data; all link inputs are async.
// Notes on behaviour
// [RULE1] User mode: request, status, done all high
// [RULE2] Request low restarts configuration, even in user
// [RULE3] Status held low through power-on delay
// [RULE4] Done low until all data accepted
// [RULE5] Host keeps config clock driven after load
// [RULE6] Data pin becomes user I/O afterwards
// [RULE7] Host sends the whole image, untruncated
// [RULE8] Done released only after every bit received
// [RULE9] Host gives two falling edges after done
// [RULE10] Init-complete pin driven low when option loaded
// [RULE11] Bit captured per rising config clock edge
// [RULE12] Host waits status high before clocking
`timescale 1ns/1ns
module pscp_device
  import pscp_pkg::*;
#(
  parameter int POR_CYC = POR_CYCLES,
  parameter int IMAGE_BITS = IMAGE_BITS_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  pscp_if.device link,
  input wire logic dual_purpose_user_io,
  input wire logic user_data_out,
  output logic user_data_in,
  output logic user_mode,
  output logic init_complete_out,
  output logic init_complete_oe_n,
  output logic config_error
);
  import pscp_pkg::*;

  logic [2:0] req_sync_reg, clk_sync_reg, dat_sync_reg;
  logic [2:0] req_sync_next;
  logic [2:0] clk_sync_next;
  logic [2:0] dat_sync_next;
  logic req_reg;
  logic req_next;
  logic cclk_reg;
  logic cclk_next;
  logic dat_reg;
  logic dat_next;
  pscp_dev_state_t state_reg, state_next;
  logic [BIT_CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0] fall_reg, fall_next;
  logic status_oe_reg;
  logic status_oe_next;
  logic done_oe_reg;
  logic done_oe_next;
  logic init_opt_reg;
  logic init_opt_next;
  logic init_oe_reg;
  logic init_oe_next;
  logic user_reg;
  logic user_next;
  logic err_reg;
  logic err_next;
  logic udi_reg;
  logic udi_next;
  logic rise, fall;

  // Stable once stages two and three agree; stage one feeds stage two only
  always_comb begin
    req_sync_next = {req_sync_reg[1:0], link.config_request_n};
    clk_sync_next = {clk_sync_reg[1:0], link.config_clock};
    dat_sync_next = {dat_sync_reg[1:0], link.serial_config_data};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_sync_reg <= 3'h7;
      clk_sync_reg <= 3'h0;
      dat_sync_reg <= 3'h0;
    end else begin
      req_sync_reg <= req_sync_next;
      clk_sync_reg <= clk_sync_next;
      dat_sync_reg <= dat_sync_next;
    end
  end

  always_comb begin
    req_next = (req_sync_reg[1] == req_sync_reg[2]) ? req_sync_reg[2] : req_reg;
    cclk_next = (clk_sync_reg[1] == clk_sync_reg[2]) ? clk_sync_reg[2] : cclk_reg;
    dat_next = (dat_sync_reg[1] == dat_sync_reg[2]) ? dat_sync_reg[2] : dat_reg;
  end
  assign rise = cclk_next & ~cclk_reg;
  assign fall = ~cclk_next & cclk_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    fall_next = fall_reg;
    status_oe_next = status_oe_reg;
    done_oe_next = done_oe_reg;
    init_opt_next = init_opt_reg;
    init_oe_next = init_oe_reg;
    user_next = user_reg;
    err_next = err_reg;
    udi_next = dat_reg;
    case (state_reg)
      PSCP_DEV_POR: begin
        status_oe_next = 1'b0;
        done_oe_next = 1'b0;
        if (cnt_reg >= BIT_CNT_W'(POR_CYC - 1)) begin // [RULE3]
          state_next = PSCP_DEV_CLEAR;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      PSCP_DEV_CLEAR: begin
        status_oe_next = 1'b0;
        done_oe_next = 1'b0;
        init_opt_next = 1'b0;
        init_oe_next = 1'b1;
        user_next = 1'b0;
        cnt_next = '0;
        if (req_reg) begin
          state_next = PSCP_DEV_LOAD;
          status_oe_next = 1'b1;
          err_next = 1'b0;
        end
      end
      PSCP_DEV_LOAD: begin
        if (rise) begin // [RULE11]
          if (cnt_reg == BIT_CNT_W'(INIT_OPT_BIT)) begin
            init_opt_next = dat_reg;
          end
          if (cnt_reg == BIT_CNT_W'(IMAGE_BITS - 1)) begin
            state_next = PSCP_DEV_INIT;
            done_oe_next = 1'b1; // [RULE4] [RULE8]
            fall_next = '0;
          end
          cnt_next = cnt_reg + 1'b1;
        end
      end
      PSCP_DEV_INIT: begin
        // The fall that closes the last bit already follows done, so it counts
        // as the first of the two; later edges are ignored once in user mode
        if (fall) begin
          fall_next = fall_reg + 1'b1;
          if (fall_reg == 2'(EXTRA_FALL_EDGES - 1)) begin
            state_next = PSCP_DEV_USER;
            user_next = 1'b1;
            init_oe_next = ~init_opt_reg; // [RULE10]
          end
        end
      end
      PSCP_DEV_USER: begin
        user_next = 1'b1; // [RULE1]
      end
      default: state_next = PSCP_DEV_CLEAR;
    endcase
    // A request restarts configuration from any state past power-on
    if (!req_reg && state_reg != PSCP_DEV_POR) begin // [RULE2]
      if (state_reg == PSCP_DEV_LOAD || state_reg == PSCP_DEV_INIT) begin
        err_next = 1'b1;
      end
      state_next = PSCP_DEV_CLEAR;
      status_oe_next = 1'b0;
      done_oe_next = 1'b0;
      user_next = 1'b0;
      init_oe_next = 1'b1;
    end
    if (!(user_reg && dual_purpose_user_io)) begin // [RULE6]
      udi_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_reg <= 1'b1;
      cclk_reg <= 1'b0;
      dat_reg <= 1'b0;
      state_reg <= PSCP_DEV_POR;
      cnt_reg <= '0;
      fall_reg <= '0;
      status_oe_reg <= 1'b0;
      done_oe_reg <= 1'b0;
      init_opt_reg <= 1'b0;
      init_oe_reg <= 1'b1;
      user_reg <= 1'b0;
      err_reg <= 1'b0;
      udi_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      cclk_reg <= cclk_next;
      dat_reg <= dat_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      fall_reg <= fall_next;
      status_oe_reg <= status_oe_next;
      done_oe_reg <= done_oe_next;
      init_opt_reg <= init_opt_next;
      init_oe_reg <= init_oe_next;
      user_reg <= user_next;
      err_reg <= err_next;
      udi_reg <= udi_next;
    end
  end

  assign link.status_out = 1'b0;
  assign link.status_oe_n = status_oe_reg;
  assign link.done_out = 1'b0;
  assign link.done_oe_n = done_oe_reg;
  assign user_data_in = udi_reg;
  assign user_mode = user_reg;
  assign init_complete_out = 1'b0;
  assign init_complete_oe_n = init_oe_reg;
  assign config_error = err_reg;
endmodule

// ==== logic/pscp_host.sv ====
// Host end: requests configuration and shifts an image out serially.
// Assumes image bits arrive from user logic, one per bit_take handshake.
`timescale 1ns/1ns
module pscp_host
  import pscp_pkg::*;
#(
  parameter int IMAGE_BITS = IMAGE_BITS_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  pscp_if.host link,
  input wire logic start,
  input wire logic bit_in,
  output logic bit_take,
  output logic busy,
  output logic done,
  output logic fail
);
  import pscp_pkg::*;

  pscp_host_state_t state_reg, state_next;
  logic [2:0] st_sync_reg, cd_sync_reg;
  logic st_reg, st_next, cd_reg, cd_next;
  logic req_reg, req_next, cclk_reg, cclk_next, dat_reg, dat_next;
  logic take_reg, take_next, fail_reg, fail_next;
  logic busy_reg, busy_next, done_reg, done_next;
  logic [BIT_CNT_W-1:0] cnt_reg, cnt_next;
  logic [3:0] div_reg, div_next;
  logic tick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_sync_reg <= 3'h0;
      cd_sync_reg <= 3'h0;
    end else begin
      st_sync_reg <= {st_sync_reg[1:0], link.config_status_n};
      cd_sync_reg <= {cd_sync_reg[1:0], link.config_complete};
    end
  end

  assign tick = (div_reg == 4'(CLK_DIV_HALF - 1));

  always_comb begin
    st_next = (st_sync_reg[1] == st_sync_reg[2]) ? st_sync_reg[2] : st_reg;
    cd_next = (cd_sync_reg[1] == cd_sync_reg[2]) ? cd_sync_reg[2] : cd_reg;
    state_next = state_reg;
    req_next = req_reg;
    cclk_next = cclk_reg;
    dat_next = dat_reg;
    take_next = 1'b0;
    fail_next = fail_reg;
    cnt_next = cnt_reg;
    div_next = tick ? 4'h0 : div_reg + 4'h1;
    case (state_reg)
      PSCP_HOST_IDLE: begin
        if (start) begin
          state_next = PSCP_HOST_REQ;
          req_next = 1'b0;
          fail_next = 1'b0;
          cnt_next = '0;
        end
      end
      PSCP_HOST_REQ: begin
        if (!st_reg) begin
          state_next = PSCP_HOST_WAIT;
          req_next = 1'b1; // [RULE2]
        end
      end
      PSCP_HOST_WAIT: begin
        if (st_reg && tick) begin // [RULE12]
          state_next = PSCP_HOST_SHIFT;
          dat_next = bit_in;
          take_next = 1'b1;
        end
      end
      PSCP_HOST_SHIFT: begin
        if (tick) begin
          cclk_next = ~cclk_reg; // [RULE11]
          if (cclk_reg) begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == BIT_CNT_W'(IMAGE_BITS - 1)) begin // [RULE7]
              state_next = PSCP_HOST_TAIL;
              cnt_next = '0;
            end else begin
              dat_next = bit_in;
              take_next = 1'b1;
            end
          end
        end
        if (!st_reg) begin
          state_next = PSCP_HOST_DONE;
          fail_next = 1'b1;
        end
      end
      PSCP_HOST_TAIL: begin
        if (tick && (cd_reg || cnt_reg != '0)) begin
          cclk_next = ~cclk_reg;
          if (cclk_reg) begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == BIT_CNT_W'(EXTRA_FALL_EDGES - 1)) begin // [RULE9]
              state_next = PSCP_HOST_DONE;
            end
          end
        end
      end
      PSCP_HOST_DONE: begin
        cclk_next = 1'b0; // [RULE5]
        if (start) begin
          state_next = PSCP_HOST_REQ;
          req_next = 1'b0;
          fail_next = 1'b0;
          cnt_next = '0;
        end
      end
      default: state_next = PSCP_HOST_IDLE;
    endcase
    // Status outputs registered from the next state so they leave a flip-flop
    busy_next = (state_next != PSCP_HOST_IDLE) && (state_next != PSCP_HOST_DONE);
    done_next = (state_next == PSCP_HOST_DONE) && !fail_next;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= PSCP_HOST_IDLE;
      st_reg <= 1'b0;
      cd_reg <= 1'b0;
      req_reg <= 1'b1;
      cclk_reg <= 1'b0;
      dat_reg <= 1'b0;
      take_reg <= 1'b0;
      fail_reg <= 1'b0;
      cnt_reg <= '0;
      div_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      st_reg <= st_next;
      cd_reg <= cd_next;
      req_reg <= req_next;
      cclk_reg <= cclk_next;
      dat_reg <= dat_next;
      take_reg <= take_next;
      fail_reg <= fail_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign link.config_request_n = req_reg;
  assign link.config_clock = cclk_reg;
  assign link.serial_config_data = dat_reg;
  assign bit_take = take_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign fail = fail_reg;
endmodule

// ==== verif/pscp_properties.sv ====
// Link checker for the passive serial configuration port.
// Assumes one clk domain; link wires arrive as plain inputs.
`timescale 1ns/1ns
module pscp_properties
  import pscp_pkg::*;
#(
  parameter int POR_CYC = POR_CYCLES,
  parameter int IMAGE_BITS = IMAGE_BITS_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic config_request_n,
  input wire logic config_clock,
  input wire logic serial_config_data,
  input wire logic config_status_n,
  input wire logic config_complete
);
  int por_cnt;
  int bits;
  logic clk_prev;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Edge count restarts whenever the device holds status low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_cnt <= 0;
      bits <= 0;
      clk_prev <= 1'b0;
    end else begin
      if (por_cnt < POR_CYC + 8) por_cnt <= por_cnt + 1;
      clk_prev <= config_clock;
      if (!config_status_n) bits <= 0;
      else if (config_clock && !clk_prev) bits <= bits + 1;
    end
  end
  chk_por_status_hold: assert property (por_cnt < POR_CYC |-> !config_status_n)
    else $error("status released inside power-on hold");
  chk_por_done_low: assert property (por_cnt < POR_CYC |-> !config_complete)
    else $error("done high inside power-on hold");
  chk_done_needs_bits: assert property (config_status_n && bits < IMAGE_BITS |-> !config_complete)
    else $error("done high before the image is in");
  chk_done_exact_count: assert property ($rose(config_complete) |-> bits == IMAGE_BITS)
    else $error("done rose on a wrong bit count");
  chk_done_stands: assert property ($rose(config_complete) |-> config_complete [*8])
    else $error("done did not stand");
  chk_user_levels: assert property ($rose(config_complete) |-> config_status_n && config_request_n)
    else $error("user mode levels not all high");
  chk_restart_pulls: assert property ($fell(config_request_n) |-> ##[1:8] (!config_status_n && !config_complete))
    else $error("request low did not restart");
  chk_release_after_req: assert property ($rose(config_request_n) && por_cnt >= POR_CYC |-> ##[1:8] config_status_n)
    else $error("status not released after request");
  chk_data_steady: assert property ($rose(config_clock) |-> $stable(serial_config_data))
    else $error("data moved at a rising link clock");
  cover property ($rose(config_complete));
  cover property ($fell(config_request_n) && config_complete);
  cover property ($rose(config_status_n));
endmodule

// ==== verif/tb_top.sv ====
// Bench: host and device joined on one link, and a second device driven
// directly by the bench, which breaks host rules on purpose.
`timescale 1ns/1ns
`define CHK(nm, ex, ac) begin check_count++; if ((ac) !== (ex)) begin fails++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, ac); end end
module tb_top;
  import pscp_pkg::*;
  localparam int POR_SIM = 20;
  localparam int NB = 16;
  localparam logic [NB-1:0] IMG_A = 16'h5A3D;
  localparam logic [NB-1:0] IMG_B = 16'h3C96;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic bit_in = 1'b0;
  logic dual_io = 1'b1;
  logic [NB-1:0] img = '0;
  int idx = 0;
  int fails = 0;
  int check_count = 0;
  logic bit_take, busy, done, fail, user_mode, init_oe_n, cfg_err, user_in;
  logic user_mode2, init_oe_n2, cfg_err2, user_in2;
  pscp_if lnk ();
  pscp_if lnk2 ();
  always #4 clk = ~clk;
  pscp_host #(.IMAGE_BITS(NB)) pscp_host_inst (.clk(clk), .rst_b(rst_b), .link(lnk.host),
    .start(start), .bit_in(bit_in), .bit_take(bit_take), .busy(busy), .done(done), .fail(fail));
  pscp_device #(.POR_CYC(POR_SIM), .IMAGE_BITS(NB)) pscp_device_inst (.clk(clk),
    .rst_b(rst_b), .link(lnk.device), .dual_purpose_user_io(dual_io), .user_data_out(1'b0),
    .user_data_in(user_in), .user_mode(user_mode), .init_complete_out(),
    .init_complete_oe_n(init_oe_n), .config_error(cfg_err));
  pscp_device #(.POR_CYC(POR_SIM), .IMAGE_BITS(NB)) pscp_device_inst2 (.clk(clk),
    .rst_b(rst_b), .link(lnk2.device), .dual_purpose_user_io(dual_io), .user_data_out(1'b0),
    .user_data_in(user_in2), .user_mode(user_mode2), .init_complete_out(),
    .init_complete_oe_n(init_oe_n2), .config_error(cfg_err2));
  pscp_properties #(.POR_CYC(POR_SIM), .IMAGE_BITS(NB)) pscp_properties_inst (.clk(clk),
    .rst_b(rst_b), .config_request_n(lnk.config_request_n), .config_clock(lnk.config_clock),
    .serial_config_data(lnk.serial_config_data), .config_status_n(lnk.config_status_n),
    .config_complete(lnk.config_complete));
  // Next image bit is presented off the sampling edge once the host took one
  always @(negedge clk) begin
    if (bit_take === 1'b1) idx = idx + 1;
    bit_in = (idx < NB) ? img[idx] : 1'b0;
  end
  task automatic host_load(input logic [NB-1:0] im);
    int i;
    img = im;
    idx = 0;
    @(negedge clk) start = 1'b1;
    @(negedge clk) start = 1'b0;
    for (i = 0; i < 10 && busy !== 1'b1; i++) @(negedge clk);
    `CHK("busy", 1'b1, busy)
    for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge clk);
    `CHK("done", 1'b1, done)
    repeat (8) @(negedge clk);
    `CHK("fail", 1'b0, fail)
    `CHK("user_in", im[NB-1], user_in)
    `CHK("complete", 1'b1, lnk.config_complete)
    `CHK("status", 1'b1, lnk.config_status_n)
    `CHK("request", 1'b1, lnk.config_request_n)
    `CHK("user_mode", 1'b1, user_mode)
    `CHK("init_oe_n", ~im[INIT_OPT_BIT], init_oe_n)
    `CHK("error", 1'b0, cfg_err)
    $display("test host_load %0h finished", im);
  endtask
  // Bench host: waits for status high before any clock edge
  task automatic b_request();
    int i;
    lnk2.config_request_n = 1'b0;
    for (i = 0; i < 50 && lnk2.config_status_n !== 1'b0; i++) @(negedge clk);
    `CHK("status_req", 1'b0, lnk2.config_status_n)
    repeat (6) @(negedge clk);
    lnk2.config_request_n = 1'b1;
    for (i = 0; i < 50 && lnk2.config_status_n !== 1'b1; i++) @(negedge clk);
    `CHK("status_free", 1'b1, lnk2.config_status_n)
  endtask
  // Link clock of 64 ns, data moved on the falling side; left driven low
  task automatic b_bits(input logic [NB-1:0] im, input int n, input int tail);
    int i;
    for (i = 0; i < n + tail; i++) begin
      lnk2.serial_config_data = (i < n) ? im[i] : 1'b0;
      repeat (4) @(negedge clk);
      lnk2.config_clock = 1'b1;
      repeat (4) @(negedge clk);
      lnk2.config_clock = 1'b0;
    end
  endtask
  task automatic fault_side();
    b_request();
    b_bits(IMG_B, NB, 2);
    repeat (8) @(negedge clk);
    `CHK("complete2", 1'b1, lnk2.config_complete)
    `CHK("user_mode2", 1'b1, user_mode2)
    `CHK("init_oe_n2", ~IMG_B[INIT_OPT_BIT], init_oe_n2)
    lnk2.serial_config_data = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("user_in_hi", 1'b1, user_in2)
    lnk2.serial_config_data = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("user_in_lo", 1'b0, user_in2)
    dual_io = 1'b0;
    lnk2.serial_config_data = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("user_in_off", 1'b0, user_in2)
    dual_io = 1'b1;
    lnk2.serial_config_data = 1'b0;
    b_request();
    b_bits(IMG_A, NB - 1, 0);
    repeat (16) @(negedge clk);
    `CHK("complete_short", 1'b0, lnk2.config_complete)
    `CHK("user_mode_short", 1'b0, user_mode2)
    lnk2.config_request_n = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("status_abort", 1'b0, lnk2.config_status_n)
    `CHK("error_abort", 1'b1, cfg_err2)
    lnk2.config_request_n = 1'b1;
    $display("test fault_side finished");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    lnk2.config_request_n = 1'b1;
    lnk2.config_clock = 1'b0;
    lnk2.serial_config_data = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (POR_SIM - 4) @(negedge clk);
    `CHK("status_por", 1'b0, lnk.config_status_n)
    `CHK("complete_por", 1'b0, lnk.config_complete)
    `CHK("status_por2", 1'b0, lnk2.config_status_n)
    $display("test power_on finished");
    host_load(IMG_A);
    host_load(IMG_B);
    fault_side();
    summarize();
  end
  // About 12500 cycles, over ten times the expected run
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule
